// >>> design/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;

   // Timing base
   localparam int unsigned CLK_PERIOD_NS       = 25;
   localparam int unsigned MIN_CONV_PERIOD_NS  = 10_000;
   localparam int unsigned MIN_CONV_PERIOD_CYC =
      (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0]  GAP_RELOAD = 9'(MIN_CONV_PERIOD_CYC - 1);
   localparam int unsigned TRACK_SAR_CLKS = 3;
   localparam int unsigned CONV_SAR_CLKS  = 16;
   localparam logic [4:0]  TRACK_LAST = 5'(TRACK_SAR_CLKS - 1);
   localparam logic [4:0]  CONV_LAST  = 5'(CONV_SAR_CLKS - 1);

   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CONFIG  = 8'h04;
   localparam logic [7:0] OFS_CHANSEL = 8'h08;
   localparam logic [7:0] OFS_PAIRCFG = 8'h0C;
   localparam logic [7:0] OFS_RES_HI  = 8'h10;
   localparam logic [7:0] OFS_RES_LO  = 8'h14;
   localparam logic [7:0] OFS_AUX     = 8'h18;

   // Control register fields
   localparam int unsigned CTL_EN_BIT   = 7;
   localparam int unsigned CTL_TM_BIT   = 6;
   localparam int unsigned CTL_DONE_BIT = 5;
   localparam int unsigned CTL_BUSY_BIT = 4;
   localparam int unsigned CTL_SRC_LSB  = 2;
   localparam int unsigned CTL_LJ_BIT   = 0;
   // Config, aux and channel select register fields
   localparam int unsigned CFG_DIV_LSB  = 3;
   localparam logic [4:0]  DIV_RESET    = 5'h1F;
   localparam logic [2:0]  GAIN_UNITY   = 3'h0;
   localparam int unsigned AUX_IRQ_BIT  = 0;
   localparam int unsigned CHAN_TEMP_BIT = 3;

   // Start sources
   localparam logic [1:0] SRC_SOFTWARE = 2'h0;
   localparam logic [1:0] SRC_TIMER3   = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h2;
   localparam logic [1:0] SRC_TIMER2   = 2'h3;

   localparam logic [9:0] SAR_FIRST = 10'h200;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [4:0] div_t;
   typedef logic [7:0] addr_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_TRACK   = 3'b010,
      ST_CONVERT = 3'b100
   } state_t;

endpackage
`default_nettype wire

// >>> design/sar_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sar_clock_gen (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              run,
   input  wire logic              restart,
   input  wire sar_adc_pkg::div_t divider,
   output logic                   sar_tick
);
   import sar_adc_pkg::*;

   typedef struct packed {
      logic [5:0] cnt;
      logic       tick;
   } divstate_t;

   divstate_t  div_r;
   divstate_t  div_nxt;
   logic [5:0] last;

   // Period of 2(N+1) cycles ends at count 2N+1; N of zero ticks every cycle
   assign last = {divider, 1'b1};

   always_comb begin
      div_nxt = div_r;
      div_nxt.tick = 1'b0;
      if (!run || restart) begin
         div_nxt.cnt = '0;
      end else if (divider == '0) begin
         div_nxt.tick = 1'b1;
      end else if (div_r.cnt == last) begin
         div_nxt.cnt = '0;
         div_nxt.tick = 1'b1;
      end else begin
         div_nxt.cnt = div_r.cnt + 6'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   assign sar_tick = div_r.tick;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_tick_gap;
      sar_tick && divider != '0 && $stable(divider) |=> !sar_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("divided converter clock ticks back to back");

   property p_tick_direct;
      run && !restart && divider == '0 |=> sar_tick;
   endproperty
   a_tick_direct: assert property (p_tick_direct)
      else $error("undivided converter clock missed a cycle");

endmodule
`default_nettype wire

// >>> design/sar_adc_conversion_control.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_control (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire sar_adc_pkg::addr_t s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire sar_adc_pkg::addr_t s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               timer3_overflow,
   input  wire logic               timer2_overflow,
   input  wire logic               external_convert_start,
   input  wire logic               chip_standby,
   input  wire logic               comparator_out,
   output logic                    converter_power_on,
   output logic                    track_enable,
   output logic [2:0]              mux_channel,
   output logic                    temp_sensor_select,
   output logic [3:0]              pair_differential,
   output logic [2:0]              gain_select,
   output logic [9:0]              sar_trial_code,
   output logic                    conversion_irq
);
   import sar_adc_pkg::*;

   typedef struct packed {
      state_t     st;
      logic       en;
      logic       tm;
      logic       done;
      logic [1:0] src;
      logic       lj;
      logic       irq_en;
      logic [4:0] div;
      logic [2:0] gain;
      logic [3:0] chan;
      logic [3:0] pair;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [9:0] trial;
      logic [9:0] mask;
      logic [4:0] tick_cnt;
      logic [8:0] gap_cnt;
      logic       diff;
      logic       ext_s1;
      logic       ext_s2;
      logic       ext_d;
      logic       aw_have;
      logic [7:0] awaddr;
      logic       w_have;
      logic [7:0] wdata;
      logic       wlane;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{st: ST_IDLE, div: DIV_RESET,
                                    gain: GAIN_UNITY, default: '0};

   ctrl_t      ctl_r;
   ctrl_t      ctl_nxt;
   logic       sar_tick;
   logic       idle;
   logic       wr_fire;
   logic       ctl_wr;
   logic       sw_start;
   logic       ext_rise;
   logic       trig;
   logic       start;
   logic [7:0] ctl_view;

   function automatic logic reg_mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= OFS_AUX);
   endfunction

   function automatic logic chan_is_diff(input logic [3:0] c,
                                         input logic [3:0] p);
      return !c[CHAN_TEMP_BIT] && p[c[2:1]];
   endfunction

   function automatic logic [15:0] fmt_result(input logic [9:0] code,
                                              input logic       dif,
                                              input logic       lj);
      logic [9:0] v;
      v = dif ? {~code[9], code[8:0]} : code;
      if (lj) begin
         return {v, 6'h00};
      end
      return {{6{dif & v[9]}}, v};
   endfunction

   sar_clock_gen sar_clock_gen_inst (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (ctl_r.en),
      .restart  (start),
      .divider  (ctl_r.div),
      .sar_tick (sar_tick)
   );

   assign idle     = ctl_r.st == ST_IDLE;
   assign wr_fire  = ctl_r.aw_have & ctl_r.w_have & ~ctl_r.bvalid;
   assign ctl_wr   = wr_fire & ctl_r.wlane & (ctl_r.awaddr == OFS_CONTROL);
   assign sw_start = ctl_wr & ctl_r.wdata[CTL_BUSY_BIT] &
                     (ctl_r.wdata[CTL_SRC_LSB +: 2] == SRC_SOFTWARE);
   assign ext_rise = ctl_r.ext_s2 & ~ctl_r.ext_d;
   assign ctl_view = {ctl_r.en, ctl_r.tm, ctl_r.done, ~idle,
                      ctl_r.src, 1'b0, ctl_r.lj};

   always_comb begin
      case (ctl_r.src)
         SRC_SOFTWARE: trig = sw_start;
         SRC_TIMER3:   trig = timer3_overflow;
         SRC_EXTERNAL: trig = ext_rise;
         SRC_TIMER2:   trig = timer2_overflow;
         default:      trig = 1'b0;
      endcase
   end

   // Spacing keeps throughput within the rated sample rate
   assign start = ctl_r.en & idle & (ctl_r.gap_cnt == '0) & trig;

   always_comb begin
      logic        done_set;
      logic        done_clr;
      logic [15:0] res;
      done_set = 1'b0;
      done_clr = 1'b0;
      res      = '0;
      ctl_nxt  = ctl_r;
      ctl_nxt.ext_s1 = external_convert_start;
      ctl_nxt.ext_s2 = ctl_r.ext_s1;
      ctl_nxt.ext_d  = ctl_r.ext_s2;
      if (ctl_r.gap_cnt != '0) begin
         ctl_nxt.gap_cnt = ctl_r.gap_cnt - 9'h1;
      end

      // Bus write channel
      if (wr_fire) begin
         ctl_nxt.aw_have = 1'b0;
         ctl_nxt.w_have  = 1'b0;
         ctl_nxt.bvalid  = 1'b1;
         ctl_nxt.bresp   = reg_mapped(ctl_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (ctl_r.wlane) begin
            case (ctl_r.awaddr)
               OFS_CONTROL: begin
                  ctl_nxt.en  = ctl_r.wdata[CTL_EN_BIT];
                  ctl_nxt.tm  = ctl_r.wdata[CTL_TM_BIT];
                  ctl_nxt.src = ctl_r.wdata[CTL_SRC_LSB +: 2];
                  ctl_nxt.lj  = ctl_r.wdata[CTL_LJ_BIT];
                  done_clr    = ~ctl_r.wdata[CTL_DONE_BIT];
               end
               OFS_CONFIG: begin
                  ctl_nxt.div  = ctl_r.wdata[CFG_DIV_LSB +: 5];
                  ctl_nxt.gain = ctl_r.wdata[2:0];
               end
               OFS_CHANSEL: ctl_nxt.chan = ctl_r.wdata[3:0];
               OFS_PAIRCFG: ctl_nxt.pair = ctl_r.wdata[3:0];
               OFS_AUX:     ctl_nxt.irq_en = ctl_r.wdata[AUX_IRQ_BIT];
               default: ;
            endcase
         end
      end
      if (ctl_r.bvalid && s_axi_bready) begin
         ctl_nxt.bvalid = 1'b0;
      end
      if (s_axi_awvalid && !ctl_r.aw_have) begin
         ctl_nxt.aw_have = 1'b1;
         ctl_nxt.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !ctl_r.w_have) begin
         ctl_nxt.w_have = 1'b1;
         ctl_nxt.wdata  = s_axi_wdata[7:0];
         ctl_nxt.wlane  = s_axi_wstrb[0];
      end

      // Bus read channel
      if (ctl_r.rvalid && s_axi_rready) begin
         ctl_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !ctl_r.rvalid) begin
         ctl_nxt.rvalid = 1'b1;
         ctl_nxt.rresp  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_CONTROL: ctl_nxt.rdata = ctl_view;
            OFS_CONFIG:  ctl_nxt.rdata = {ctl_r.div, ctl_r.gain};
            OFS_CHANSEL: ctl_nxt.rdata = {4'h0, ctl_r.chan};
            OFS_PAIRCFG: ctl_nxt.rdata = {4'h0, ctl_r.pair};
            OFS_RES_HI:  ctl_nxt.rdata = ctl_r.res_hi;
            OFS_RES_LO:  ctl_nxt.rdata = ctl_r.res_lo;
            OFS_AUX:     ctl_nxt.rdata = {7'h00, ctl_r.irq_en};
            default:     ctl_nxt.rdata = 8'h00;
         endcase
      end

      // Conversion sequencer
      case (ctl_r.st)
         ST_IDLE: begin
            if (start) begin
               ctl_nxt.gap_cnt  = GAP_RELOAD;
               ctl_nxt.tick_cnt = '0;
               ctl_nxt.diff     = chan_is_diff(ctl_r.chan, ctl_r.pair);
               ctl_nxt.trial    = SAR_FIRST;
               ctl_nxt.mask     = SAR_FIRST;
               // Pin start in low-power mode has tracked while low
               if (ctl_r.tm && ctl_r.src != SRC_EXTERNAL) begin
                  ctl_nxt.st = ST_TRACK;
               end else begin
                  ctl_nxt.st = ST_CONVERT;
               end
            end
         end
         ST_TRACK: begin
            if (sar_tick) begin
               if (ctl_r.tick_cnt == TRACK_LAST) begin
                  ctl_nxt.tick_cnt = '0;
                  ctl_nxt.st       = ST_CONVERT;
               end else begin
                  ctl_nxt.tick_cnt = ctl_r.tick_cnt + 5'h1;
               end
            end
         end
         ST_CONVERT: begin
            if (sar_tick) begin
               // Bits decided on the first ten ticks, rest is margin
               if (ctl_r.mask != '0) begin
                  ctl_nxt.trial = (comparator_out ? ctl_r.trial
                                   : ctl_r.trial & ~ctl_r.mask)
                                  | (ctl_r.mask >> 1);
                  ctl_nxt.mask  = ctl_r.mask >> 1;
               end
               if (ctl_r.tick_cnt == CONV_LAST) begin
                  res            = fmt_result(ctl_r.trial, ctl_r.diff,
                                              ctl_r.lj);
                  ctl_nxt.res_hi = res[15:8];
                  ctl_nxt.res_lo = res[7:0];
                  ctl_nxt.st     = ST_IDLE;
                  done_set       = 1'b1;
               end else begin
                  ctl_nxt.tick_cnt = ctl_r.tick_cnt + 5'h1;
               end
            end
         end
         default: ctl_nxt.st = ST_IDLE;
      endcase

      // Disable aborts any conversion in flight
      if (!ctl_nxt.en) begin
         ctl_nxt.st = ST_IDLE;
      end
      // Completion in the clearing cycle is kept
      ctl_nxt.done = done_set | (ctl_r.done & ~done_clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_r <= CTRL_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   assign s_axi_awready      = ~ctl_r.aw_have;
   assign s_axi_wready       = ~ctl_r.w_have;
   assign s_axi_bvalid       = ctl_r.bvalid;
   assign s_axi_bresp        = ctl_r.bresp;
   assign s_axi_arready      = ~ctl_r.rvalid;
   assign s_axi_rvalid       = ctl_r.rvalid;
   assign s_axi_rresp        = ctl_r.rresp;
   assign s_axi_rdata        = {24'h00_0000, ctl_r.rdata};
   assign converter_power_on = ctl_r.en;
   assign mux_channel        = ctl_r.chan[2:0];
   assign temp_sensor_select = ctl_r.chan[CHAN_TEMP_BIT];
   assign pair_differential  = ctl_r.pair;
   assign gain_select        = ctl_r.gain;
   assign sar_trial_code     = ctl_r.trial;
   assign conversion_irq     = ctl_r.done & ctl_r.irq_en;
   assign track_enable = ctl_r.en & ~chip_standby &
      (ctl_r.tm ? (ctl_r.src == SRC_EXTERNAL ? idle & ~ctl_r.ext_s2
                   : ctl_r.st == ST_TRACK)
       : ctl_r.st != ST_CONVERT);

   // Ticks spent per conversion, for checking only
   logic [4:0] chk_ticks;
   logic       chk_lp;
   always_ff @(posedge aclk) begin
      if (!aresetn || start) begin
         chk_ticks <= '0;
         chk_lp    <= ctl_r.tm & (ctl_r.src != SRC_EXTERNAL);
      end else if (!idle && sar_tick) begin
         chk_ticks <= chk_ticks + 5'h1;
      end
   end

   localparam int LP_LAST_I = 18;
   localparam int CV_LAST_I = 15;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_conv_end;
      ctl_r.st == ST_CONVERT && sar_tick && ctl_r.tick_cnt == CONV_LAST;
   endsequence

   property p_shutdown;
      !ctl_r.en |-> idle && !track_enable && !converter_power_on;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("activity while converter disabled");

   property p_busy_done;
      $fell(ctl_view[CTL_BUSY_BIT]) && ctl_r.en |-> ctl_r.done;
   endproperty
   a_busy_done: assert property (p_busy_done)
      else $error("busy fell without setting done");

   property p_done_sticky;
      ctl_r.done && !ctl_wr |=> ctl_r.done;
   endproperty
   a_done_sticky: assert property (p_done_sticky)
      else $error("done cleared without a software write");

   property p_conv_len;
      s_conv_end ##0 ctl_r.en
         |-> chk_ticks == (chk_lp ? LP_LAST_I : CV_LAST_I);
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion tick count wrong");

   property p_sw_start;
      sw_start && ctl_r.src == SRC_SOFTWARE && start && ctl_wr
         && ctl_r.wdata[CTL_EN_BIT] |=> ctl_view[CTL_BUSY_BIT] [*2];
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software start did not raise busy");

   property p_gap;
      start |=> (ctl_r.gap_cnt == GAP_RELOAD) ##1 !start;
   endproperty
   a_gap: assert property (p_gap)
      else $error("start spacing not enforced");

   property p_ext_track;
      ctl_r.en && ctl_r.tm && ctl_r.src == SRC_EXTERNAL && idle
         && !chip_standby |-> track_enable == !ctl_r.ext_s2;
   endproperty
   a_ext_track: assert property (p_ext_track)
      else $error("pin-driven tracking wrong");

   property p_cont_track;
      ctl_r.en && !ctl_r.tm && !chip_standby && ctl_r.st != ST_CONVERT
         |-> track_enable;
   endproperty
   a_cont_track: assert property (p_cont_track)
      else $error("continuous tracking dropped");

   property p_right_fill;
      s_conv_end ##0 (ctl_r.en && !ctl_r.lj && !ctl_r.diff)
         |=> ctl_r.res_hi[7:2] == 6'h00 && ctl_r.res_lo == ctl_r.trial[7:0];
   endproperty
   a_right_fill: assert property (p_right_fill)
      else $error("right-justified result misplaced");

endmodule
`default_nettype wire

// >>> tb/analog_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
   input  wire logic [9:0] sar_trial_code,
   input  wire logic [9:0] sample_code,
   output logic            comparator_out
);
   // Held sample at or above the trial code keeps the bit
   assign comparator_out = (sample_code >= sar_trial_code);
endmodule
`default_nettype wire

// >>> tb/sar_adc_conversion_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_control_test;
   import sar_adc_pkg::*;
   logic        aclk = 0, aresetn = 0;
   addr_t       s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic        s_axi_bready = 1, s_axi_rready = 1;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, comparator_out;
   logic        timer3_overflow = 0, timer2_overflow = 0;
   logic        external_convert_start = 0, chip_standby = 0;
   logic        converter_power_on, track_enable, temp_sensor_select;
   logic        conversion_irq;
   logic [2:0]  mux_channel, gain_select;
   logic [3:0]  pair_differential;
   logic [9:0]  sar_trial_code, vin = 0;
   int          failures = 0, check_count = 0, seed = 30339;

   sar_adc_conversion_control sar_adc_conversion_control_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .timer3_overflow(timer3_overflow), .timer2_overflow(timer2_overflow),
      .external_convert_start(external_convert_start),
      .chip_standby(chip_standby), .comparator_out(comparator_out),
      .converter_power_on(converter_power_on), .track_enable(track_enable),
      .mux_channel(mux_channel), .temp_sensor_select(temp_sensor_select),
      .pair_differential(pair_differential), .gain_select(gain_select),
      .sar_trial_code(sar_trial_code), .conversion_irq(conversion_irq));

   analog_front_model analog_front_model_inst (
      .sar_trial_code(sar_trial_code), .sample_code(vin),
      .comparator_out(comparator_out));

   always #12.5 aclk = ~aclk;

   task automatic chk(input logic [15:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input addr_t a, input logic [7:0] d,
                     input logic [1:0] er);
      int   n = 0;
      logic aw = 0, w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w) && n < 64) begin
         @(posedge aclk);
         n++;
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid && n < 64) begin
         @(posedge aclk);
         n++;
      end
      chk({14'h0000, s_axi_bresp}, {14'h0000, er}, "bresp");
      chk(16'(n < 64), 16'h0001, "write hang");
   endtask

   task automatic rd(input addr_t a, output logic [7:0] d,
                     input logic [1:0] er);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!s_axi_arready && n < 64);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid && n < 64) begin
         @(posedge aclk);
         n++;
      end
      d = s_axi_rdata[7:0];
      chk({14'h0000, s_axi_rresp}, {14'h0000, er}, "rresp");
      chk(s_axi_rdata[31:16] | s_axi_rdata[15:8], 16'h0000, "rdata top");
   endtask

   function automatic logic [15:0] exp_word(logic [9:0] v, logic dif,
                                            logic lj);
      logic [9:0] c;
      c = dif ? v ^ 10'h200 : v;
      if (lj) return {c, 6'h00};
      return {{6{dif & c[9]}}, c};
   endfunction

   // Spacing of 400 cycles after each conversion keeps the throughput limit happy
   task automatic conv(input logic [1:0] src, input logic tm, dif, lj,
                       input logic [4:0] div);
      logic [7:0] ctl, hi, lo;
      logic [3:0] ch;
      logic [2:0] g;
      int         k, p, c = 0;
      vin = 10'($random(seed));
      ch = dif ? 4'h0 : 4'($random(seed));
      g = 3'($random(seed));
      p = div == 0 ? 1 : 2 * (div + 1);
      k = (tm && src != SRC_EXTERNAL) ? 19 : 16;
      ctl = {1'b1, tm, 2'b00, src, 1'b0, lj};
      wr(OFS_PAIRCFG, {7'h00, dif}, RESP_OKAY);
      wr(OFS_CHANSEL, {4'h0, ch}, RESP_OKAY);
      wr(OFS_CONFIG, {div, g}, RESP_OKAY);
      chk({mux_channel, temp_sensor_select, 1'b0, gain_select,
           pair_differential},
          {ch[2:0], ch[3], 1'b0, g, 3'h0, dif}, "mux");
      // Input settles 1.5 us after a mux or gain change
      repeat (60) @(posedge aclk);
      wr(OFS_CONTROL, ctl, RESP_OKAY);
      chk(16'(track_enable), 16'(!tm || src == SRC_EXTERNAL),
          "track");
      if (src == SRC_SOFTWARE) begin
         wr(OFS_CONTROL, ctl | 8'h10, RESP_OKAY);
         rd(OFS_CONTROL, hi, RESP_OKAY);
         chk({8'h00, hi & 8'h10}, 16'h0010, "busy");
      end
      timer3_overflow <= (src == SRC_TIMER3);
      timer2_overflow <= (src == SRC_TIMER2);
      external_convert_start <= (src == SRC_EXTERNAL);
      @(posedge aclk);
      timer3_overflow <= 1'b0;
      timer2_overflow <= 1'b0;
      while (!conversion_irq && c < 3000) begin
         @(posedge aclk);
         c++;
      end
      chk(16'(c >= k * p - 8 && c <= k * p + 8), 16'h0001,
          "span");
      rd(OFS_RES_HI, hi, RESP_OKAY);
      rd(OFS_RES_LO, lo, RESP_OKAY);
      chk({hi, lo}, exp_word(vin, dif, lj), "result");
      wr(OFS_CONTROL, ctl | 8'h20, RESP_OKAY);
      chk(16'(conversion_irq), 16'h0001, "done kept");
      wr(OFS_AUX, 8'h00, RESP_OKAY);
      chk(16'(conversion_irq), 16'h0000, "irq masked");
      wr(OFS_AUX, 8'h01, RESP_OKAY);
      wr(OFS_CONTROL, ctl, RESP_OKAY);
      rd(OFS_CONTROL, hi, RESP_OKAY);
      chk({7'h00, conversion_irq, hi}, {8'h00, ctl}, "cleared");
      external_convert_start <= 1'b0;
      repeat (400) @(posedge aclk);
      $display("test conversion source %0d mode %0d done", src, tm);
   endtask

   task tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      failures++;
      tally_and_finish;
   end

   initial begin
      logic [7:0] d;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CONFIG, d, RESP_OKAY);
      chk({8'h00, d}, 16'h00F8, "config reset");
      rd(OFS_PAIRCFG, d, RESP_OKAY);
      chk({8'h00, d}, 16'h0000, "pair reset");
      rd(8'h1D, d, RESP_SLVERR);
      chk({8'h00, d}, 16'h0000, "unmapped");
      wr(8'h20, 8'hFF, RESP_SLVERR);
      chk({gain_select, converter_power_on, track_enable}, 16'h0000,
          "off");
      $display("test reset done");
      wr(OFS_AUX, 8'h01, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         // Every pairing of differential and justification is reached
         conv(2'(i), 1'(i / 4), 1'(i ^ (i / 4)), 1'((i / 2) ^ (i / 4)),
              5'(i % 2));
      end
      wr(OFS_CONTROL, 8'h80, RESP_OKAY);
      chip_standby <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(16'(track_enable), 16'h0000, "standby");
      chip_standby <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(16'(track_enable), 16'h0001, "tracking");
      wr(OFS_CONFIG, 8'hF8, RESP_OKAY);
      wr(OFS_CONTROL, 8'h90, RESP_OKAY);
      wr(OFS_CONTROL, 8'h00, RESP_OKAY);
      rd(OFS_CONTROL, d, RESP_OKAY);
      repeat (1100) @(posedge aclk);
      chk({d, converter_power_on, track_enable, conversion_irq}, 16'h0000,
          "abort");
      $display("test abort done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
